// >>> include/asc_pkg.sv
`default_nettype none
package asc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 4;
  // fastest-grade figures, in ns
  localparam int T_READ_ACCESS_NS = 25;
  localparam int T_STROBE_PULSE_NS = 15;
  localparam int T_ADDR_TO_END_NS = 20;
  localparam int T_DATA_SETUP_STROBE_NS = 15;
  localparam int T_DATA_SETUP_SELECT_NS = 10;
  localparam int T_WRITE_CYCLE_NS = 20;
  localparam int T_STROBE_TO_OUTPUT_FLOAT_NS = 15;
  localparam int T_SELECT_TO_FLOAT_NS = 20;
  localparam int T_OUTPUT_REDRIVE_NS = 5;
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cycles
  // +2 covers the two-flop sampling of read data
  localparam int READ_CYC = ceil_cycles(T_READ_ACCESS_NS) + 2;
  localparam int FLOAT_CYC = ceil_cycles(T_STROBE_TO_OUTPUT_FLOAT_NS);
  localparam int PULSE_CYC = ceil_cycles(T_ADDR_TO_END_NS);
  localparam int SETUP_STROBE_CYC = ceil_cycles(T_DATA_SETUP_STROBE_NS);
  localparam int SETUP_SELECT_CYC = ceil_cycles(T_DATA_SETUP_SELECT_NS);
  localparam int RECOVER_CYC = ceil_cycles(T_SELECT_TO_FLOAT_NS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    ASC_IDLE = 3'b000,
    ASC_READ = 3'b001,
    ASC_WFLOAT = 3'b010,
    ASC_WDATA = 3'b011,
    ASC_WEND = 3'b100,
    ASC_RECOVER = 3'b101
  } asc_state_t;
endpackage : asc_pkg
`default_nettype wire

// >>> src/asc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [asc_pkg::DATA_W-1:0] din,
  output logic [asc_pkg::DATA_W-1:0] dout
);
  logic [asc_pkg::DATA_W-1:0] stage1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 4'h0;
      dout <= 4'h0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : asc_sync
`default_nettype wire

// >>> src/asc_host.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - read holds strobe high, select low
// - write begins when both go low
// - drive data only after output float
// - address changes only while deselected
// - strobe write address and pulse minimums
// - strobe write data setup minimum
// - select write data setup minimum
// - select write address and cycle minimums
module asc_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqSelectEnd,
  input wire logic [asc_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [asc_pkg::DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [asc_pkg::DATA_W-1:0] rspData,
  output logic [asc_pkg::ADDR_W-1:0] wordAddress,
  output logic selectN,
  output logic strobeN,
  output logic [asc_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [asc_pkg::DATA_W-1:0] dataIn
);
  asc_pkg::asc_state_t state;
  logic [asc_pkg::CNT_W-1:0] cnt;
  logic selEnd;
  logic [asc_pkg::DATA_W-1:0] dataSync;
  logic take;
  logic cntDone;
  logic rdLast;

  asc_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(dataIn),
    .dout(dataSync)
  );

  assign reqReady = (state == asc_pkg::ASC_IDLE);
  assign take = reqValid && reqReady;
  assign cntDone = (cnt == asc_pkg::CNT_ZERO);
  assign rdLast = (state == asc_pkg::ASC_READ) && cntDone;

  // a load of n-1 gives n clocks in the phase, so counts round up
  function automatic logic [asc_pkg::CNT_W-1:0] cyc(input int n);
    return asc_pkg::CNT_W'(n - 1);
  endfunction : cyc

  function automatic logic [asc_pkg::CNT_W-1:0] countDown(input logic [asc_pkg::CNT_W-1:0] c);
    return c - 4'h1;
  endfunction : countDown

  // phase sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= asc_pkg::ASC_IDLE;
    end else begin
      unique case (state)
        asc_pkg::ASC_IDLE: begin
          if (take && reqWrite) begin
            state <= asc_pkg::ASC_WFLOAT;
          end else if (take) begin
            state <= asc_pkg::ASC_READ;
          end
        end
        asc_pkg::ASC_READ: begin
          if (cntDone) begin
            state <= asc_pkg::ASC_RECOVER;
          end
        end
        asc_pkg::ASC_WFLOAT: begin
          if (cntDone) begin
            state <= asc_pkg::ASC_WDATA;
          end
        end
        asc_pkg::ASC_WDATA: begin
          if (cntDone) begin
            state <= asc_pkg::ASC_WEND;
          end
        end
        asc_pkg::ASC_WEND: begin
          state <= asc_pkg::ASC_RECOVER;
        end
        asc_pkg::ASC_RECOVER: begin
          // memory may drive up to float time after deselect
          if (cntDone) begin
            state <= asc_pkg::ASC_IDLE;
          end
        end
        default: begin
          state <= asc_pkg::ASC_IDLE;
        end
      endcase
    end
  end

  // one down-counter times every phase except ASC_IDLE and the one-clock ASC_WEND
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= asc_pkg::CNT_ZERO;
    end else begin
      unique case (state)
        asc_pkg::ASC_IDLE: begin
          if (take && reqWrite) begin
            cnt <= cyc(asc_pkg::FLOAT_CYC);
          end else if (take) begin
            cnt <= cyc(asc_pkg::READ_CYC);
          end
        end
        asc_pkg::ASC_READ: begin
          cnt <= cntDone ? cyc(asc_pkg::RECOVER_CYC) : countDown(cnt);
        end
        asc_pkg::ASC_WFLOAT: begin
          // longer of pulse/address window and data setup
          cnt <= cntDone ? cyc(asc_pkg::PULSE_CYC) : countDown(cnt);
        end
        asc_pkg::ASC_WDATA, asc_pkg::ASC_RECOVER: begin
          if (!cntDone) begin
            cnt <= countDown(cnt);
          end
        end
        asc_pkg::ASC_WEND: begin
          cnt <= cyc(asc_pkg::RECOVER_CYC);
        end
        default: begin
          cnt <= asc_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // address moves only while deselected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wordAddress <= 10'h000;
      dataOut <= 4'h0;
      selEnd <= 1'b0;
    end else if (take) begin
      wordAddress <= reqAddr;
      dataOut <= reqData;
      selEnd <= reqSelectEnd;
    end
  end

  // select: low from take to the end of each transfer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selectN <= 1'b1;
    end else begin
      unique case (state)
        asc_pkg::ASC_IDLE: begin
          if (take) begin
            selectN <= 1'b0;
          end
        end
        asc_pkg::ASC_READ: begin
          if (cntDone) begin
            selectN <= 1'b1;
          end
        end
        asc_pkg::ASC_WDATA: begin
          if (cntDone && selEnd) begin
            selectN <= 1'b1;
          end
        end
        asc_pkg::ASC_WFLOAT, asc_pkg::ASC_RECOVER: begin
          selectN <= selectN;
        end
        asc_pkg::ASC_WEND: begin
          selectN <= 1'b1;
        end
        default: begin
          selectN <= 1'b1;
        end
      endcase
    end
  end

  // strobe with select: no output glitch to float
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobeN <= 1'b1;
    end else begin
      unique case (state)
        asc_pkg::ASC_IDLE: begin
          if (take && reqWrite) begin
            strobeN <= 1'b0;
          end else if (take) begin
            strobeN <= 1'b1;
          end
        end
        asc_pkg::ASC_WDATA: begin
          if (cntDone && !selEnd) begin
            strobeN <= 1'b1;
          end
        end
        asc_pkg::ASC_READ, asc_pkg::ASC_WFLOAT, asc_pkg::ASC_RECOVER: begin
          strobeN <= strobeN;
        end
        asc_pkg::ASC_WEND: begin
          strobeN <= 1'b1;
        end
        default: begin
          strobeN <= 1'b1;
        end
      endcase
    end
  end

  // bus driven only once the memory has let go of it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOe <= 1'b0;
    end else begin
      unique case (state)
        asc_pkg::ASC_WFLOAT: begin
          if (cntDone) begin
            dataOe <= 1'b1;
          end
        end
        asc_pkg::ASC_WEND: begin
          // zero hold allowed; drop data a clock after the write ends, on the edge that raises the other control
          dataOe <= 1'b0;
        end
        asc_pkg::ASC_IDLE, asc_pkg::ASC_READ, asc_pkg::ASC_WDATA, asc_pkg::ASC_RECOVER: begin
          dataOe <= dataOe;
        end
        default: begin
          dataOe <= 1'b0;
        end
      endcase
    end
  end

  // sampled at end of access window, through synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid <= 1'b0;
      rspData <= 4'h0;
    end else begin
      rspValid <= rdLast;
      if (rdLast) begin
        rspData <= dataSync;
      end
    end
  end
endmodule : asc_host
`default_nettype wire

// >>> sim/asc_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic selectN,
  input wire logic strobeN,
  input wire logic dataOe,
  input wire logic [9:0] wordAddress
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr;
    !selectN && !strobeN;
  endsequence
  a_addr_hold:
    assert property (s_wr ##1 s_wr |-> $stable(wordAddress)) else $error("addr moved");
  a_both_low:
    assert property ($fell(strobeN) |-> !selectN) else $error("strobe alone");
  a_float_wait:
    assert property ($fell(strobeN) |-> !dataOe [*4]) else $error("early drive");
  a_pulse_min:
    assert property ($fell(strobeN) |-> !strobeN [*5]) else $error("short strobe");
  a_data_strobe:
    assert property ($rose(strobeN) && !selectN |-> $past(dataOe, 4)) else $error("setup");
  a_data_select:
    assert property ($rose(selectN) && !$past(strobeN) |-> $past(dataOe, 3)) else $error("setup");
  a_cycle_min:
    assert property ($fell(selectN) && !strobeN |-> !selectN [*5]) else $error("short write");
  a_read_quiet:
    assert property ($fell(selectN) && strobeN |-> (strobeN && !dataOe) [*8]) else $error("rd");
endmodule : asc_host_properties
bind asc_host asc_host_properties u_chk (.clk, .arst_n, .selectN, .strobeN, .dataOe,
  .wordAddress);
`default_nettype wire

// >>> sim/asc_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
  input wire logic [9:0] wordAddress,
  input wire logic selectN,
  input wire logic strobeN,
  input wire logic dataOe,
  input wire logic [3:0] dataOut,
  output logic [3:0] dataIn
);
  logic [3:0] mem [1024];
  logic [3:0] q;
  logic rdDly;
  wire rd = !selectN && strobeN;
  assign #25 q = mem[wordAddress];
  assign #25 rdDly = rd;
  // released bus shows the inverse, so stale data never passes
  assign dataIn = dataOe ? dataOut : (rd && rdDly) ? q : ~q;
  // level write avoids racing the closing edge against dataOe
  always @* begin
    if (!selectN && !strobeN && dataOe) mem[wordAddress] = dataOut;
  end
endmodule : asc_sram_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqSelectEnd = 1'b0;
  logic [9:0] reqAddr = 10'h000;
  logic [3:0] reqData = 4'h0;
  logic reqReady, rspValid, selectN, strobeN, dataOe;
  logic [3:0] rspData, dataOut, dataIn;
  logic [9:0] wordAddress;
  int num_errors = 0;
  int compares = 0;
  int i;
  // write flag, select-ended flag, address, data or expected read
  logic [15:0] rows [6] = '{16'h8005, 16'hfffa, 16'h0005, 16'h3ffa, 16'hbff3, 16'h3ff3};
  always #2 clk = ~clk;
  asc_host DUT (.clk, .arst_n, .reqValid, .reqReady, .reqWrite, .reqSelectEnd, .reqAddr,
    .reqData, .rspValid, .rspData, .wordAddress, .selectN, .strobeN, .dataOut, .dataOe, .dataIn);
  asc_sram_model mem (.wordAddress, .selectN, .strobeN, .dataOe, .dataOut, .dataIn);
  task summarize;
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick;
    @(negedge clk);
    i++;
    if (i > 50) begin
      num_errors++;
      summarize();
    end
  endtask : tick
  task run(input logic [15:0] r);
    @(posedge clk);
    {reqWrite, reqSelectEnd, reqAddr, reqData} <= r;
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    // look off the edge: ready still shows idle in the take step
    @(negedge clk);
    i = 0;
    if (!r[15]) begin
      while (rspValid !== 1'b1) tick();
      chk(rspData, r[3:0]);
    end
    i = 0;
    while (reqReady !== 1'b1) tick();
  endtask : run
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 6; k++) run(rows[k]);
    // reset lands before data is driven, so the old word must survive
    fork
      run(16'h8009);
    join_none
    repeat (4) @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk({selectN, strobeN, dataOe, reqReady}, 4'hd);
    @(posedge clk);
    arst_n <= 1'b1;
    run(16'h0005);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
